//--- verilog/eanl_map.svh
// Purpose: offsets, field positions, reset values and counts for the
//          energy accumulation and idle-load control block
// Assumes: AHB-Lite byte addresses, one 32-bit word per register
// Notes:   energy index = phase * 4 + type (active, reactive, apparent,
//          fundamental reactive)
//
// Behaviour
// RULE1: active mode 10 accumulates positive energy only
// RULE2: active modes 00 signed, 01 absolute, 11 negative
// RULE3: signed active energy keeps sign in top bit
// RULE4: reactive mode 01 accumulates absolute reactive energy
// RULE5: reactive modes 00 signed, 10 positive, 11 negative
// RULE6: idle decided per phase and per energy
// RULE7: window codes 0..6 give 64..4096 samples, 7 disables
// RULE8: reset leaves detection on, 64-sample window
// RULE9: thresholds for active, both reactive, apparent
// RULE10: idle energy adds zero each sample
// RULE11: power accumulators ignore idle state
// RULE12: idle flags per phase and energy type
// RULE13: per-type enables raise second interrupt on change
// RULE14: idle status selectable onto event pin
// RULE15: signed 42-bit internal accumulator per energy
// RULE16: update tick after count plus one samples/halves
// RULE17: period count field is 13 bits wide
// RULE18: half-cycle mode counts selected zero-crossing source
// RULE19: software keeps half-cycle count below 2640
// RULE20: tick adds or loads user register, clears internal
// RULE21: clear-on-read zeroes high part only
// RULE22: accumulators run only while run bit set
// RULE23: 45-bit user energy, 32-bit high, 13-bit low
// RULE24: window end sets or clears idle, restarts
`ifndef EANL_MAP_SVH
`define EANL_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define EANL_OFF_ACCUMULATION_MODE_CFG    12'h000
`define EANL_OFF_EPCFG      12'h004
`define EANL_OFF_PERIOD     12'h008
`define EANL_OFF_ZXSEL      12'h00c
`define EANL_OFF_ACT_THR    12'h010
`define EANL_OFF_REACT_THR  12'h014
`define EANL_OFF_APP_THR    12'h018
`define EANL_OFF_IDLE_FLAGS 12'h01c
`define EANL_OFF_STATUS     12'h020
`define EANL_OFF_IRQ_EN     12'h024
`define EANL_OFF_USER_BASE  12'h040
`define EANL_OFF_PACC_BASE  12'h100

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define EANL_CFG_RUN        0
`define EANL_CFG_PMODE      1
`define EANL_CFG_LOAD       2
`define EANL_CFG_RDRST      3
`define EANL_CFG_WIN_LSB    4
`define EANL_CFG_EVT        7
`define EANL_WIN_OFF        3'h7
`define EANL_RST_WIN        3'h0
`define EANL_RST_PERIOD     13'h0000

// ---------------------------------------------------------------
// widths and counts
// ---------------------------------------------------------------
`define EANL_NRG            12
`define EANL_PWR_W          32
`define EANL_INT_W          42
`define EANL_USER_W         45
`define EANL_LO_W           13
`define EANL_WSUM_W         44
`define EANL_WIN_BASE       12'h03f

`endif

//--- verilog/eanl_pkg.sv
// Purpose: types shared by the energy accumulation control block
// Assumes: constants live in eanl_map.svh
// Notes:   none
`default_nettype none

package eanl_pkg;

	// sign handling of one energy accumulation
	typedef enum logic [1:0] {
		EANL_SIGNED = 2'b00,
		EANL_ABS    = 2'b01,
		EANL_POS    = 2'b10,
		EANL_NEG    = 2'b11
	} eanl_sign_e;

	// one sample of all twelve powers, index phase*4+type
	typedef struct packed {
		logic             valid;
		logic [11:0][31:0] p;
	} eanl_power_s;

	// per-sample contribution handed to the pulse-output stage
	typedef struct packed {
		logic             valid;
		logic [11:0][32:0] e;
	} eanl_pulse_s;

endpackage

`default_nettype wire

//--- verilog/eanl_ctrl.sv
// Purpose: energy accumulation, idle-load detection and update tick
// Assumes: power samples and zero-crossing pulses come from logic on hclk
// Notes:   reads take one wait state; writes take none
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "eanl_map.svh"
`default_nettype none

module eanl_ctrl (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	// ahb-lite slave
	input  wire logic                hsel,
	input  wire logic [11:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic                     hresp,
	output logic [31:0]              hrdata,
	// datapath side
	input  wire eanl_pkg::eanl_power_s power_in,
	input  wire logic [3:0]          zx_pulse,
	output eanl_pkg::eanl_pulse_s    energy_pulse_output,
	output logic                     energy_update_tick,
	output logic                     second_interrupt_line_n,
	output logic                     event_n
);

	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------

	// signed contribution of one sample under a sign mode
	function automatic logic signed [32:0] contrib(
		input logic [31:0] p,
		input logic [1:0]  mode
	);
		logic signed [32:0] ps;
		ps = {p[31], p};
		case (mode)
			// RULE2: absolute value
			2'b01: contrib = p[31] ? -ps : ps;
			// RULE1: positive only
			2'b10: contrib = p[31] ? 33'sh0 : ps;
			// RULE2: negative only
			2'b11: contrib = p[31] ? ps : 33'sh0;
			default: contrib = ps;
		endcase
	endfunction

	// magnitude of one sample, widened for the window sum
	function automatic logic [43:0] mag(input logic [31:0] p);
		logic [32:0] a;
		a = p[31] ? (33'h0 - {1'b1, p}) : {1'b0, p};
		mag = {11'h000, a};
	endfunction

	// ---------------------------------------------------------------
	// configuration and state
	// ---------------------------------------------------------------
	logic [1:0]  act_mode;            // active_sign_mode
	logic [1:0]  react_mode;          // reactive_sign_mode
	logic        run_en;              // accumulator_run_en
	logic        period_mode;         // energy_period_mode
	logic        load_sel;            // energy_load_or_add
	logic        rdrst_en;            // clear high part on read
	logic [2:0]  win_sel;             // idle_window_sel
	logic        evt_sel;             // idle status onto event pin
	logic [12:0] period_cnt;          // energy_period_count
	logic [1:0]  zx_src;              // zero_cross_source
	logic [31:0] thr [3];             // idle thresholds
	logic [3:0]  status;              // sticky idle-change flags
	logic [3:0]  irq_en;              // per-type interrupt enables
	logic [11:0] idle;                // phase_idle_flags
	logic [11:0] next_idle;           // idle flags after this cycle
	logic [12:0] per_q;               // samples or halves counted
	logic [11:0] win_q;               // samples in current window
	logic [44:0] user_nrg [12];       // user energy registers
	logic [41:0] int_nrg  [12];       // internal accumulators
	logic [43:0] wsum     [12];       // window magnitude sums
	logic [41:0] pacc     [12];       // running power accumulators
	logic [31:0] pacc_q   [12];       // latched power accumulators
	logic [11:0] addr_q;              // data-phase address
	logic        wr_q;                // write data phase pending
	logic        rd_q;                // read wait state pending

	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire        req      = hsel & hready & htrans[1];
	wire        wr_fire  = wr_q;
	wire        rd_fire  = rd_q;
	wire [11:0] user_off = addr_q - `EANL_OFF_USER_BASE;
	wire [11:0] pacc_off = addr_q - `EANL_OFF_PACC_BASE;
	wire        in_user  = (addr_q >= `EANL_OFF_USER_BASE) &&
		(addr_q < `EANL_OFF_USER_BASE + 12'h060);
	wire        in_pacc  = (addr_q >= `EANL_OFF_PACC_BASE) &&
		(addr_q < `EANL_OFF_PACC_BASE + 12'h030);
	wire [3:0]  user_idx = user_off[6:3];
	wire [3:0]  pacc_idx = pacc_off[5:2];
	wire        user_hi  = ~user_off[2];
	wire        w_cfg    = wr_fire && addr_q == `EANL_OFF_EPCFG;
	wire        w_status = wr_fire && addr_q == `EANL_OFF_STATUS;

	// ---------------------------------------------------------------
	// sample strobes and timing
	// ---------------------------------------------------------------
	// RULE22: nothing accumulates while the run bit is clear
	wire        smp      = power_in.valid & run_en;
	// RULE18: half-cycle mode counts the chosen crossing source
	wire        zx_hit   = zx_pulse[zx_src];
	// RULE16: step on samples or on half line cycles
	wire        per_step = run_en & (period_mode ? zx_hit : power_in.valid);
	wire        tick     = per_step && per_q == period_cnt;
	// RULE7: code 7 switches detection off
	wire        win_on   = win_sel != `EANL_WIN_OFF;
	wire [11:0] win_last = 12'((`EANL_WIN_BASE << win_sel) | 12'h03f);
	// RULE24: window ends on its last sample
	wire        win_end  = smp && win_on && win_q == win_last;

	// ---------------------------------------------------------------
	// per-energy datapath
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `EANL_NRG; gi++) begin : g_nrg
			localparam int TY = gi % 4;
			wire [31:0] p = power_in.p[gi];
			// RULE5: reactive sign modes
			// RULE4: reactive and fundamental share the reactive mode
			wire [1:0]  mode = (TY == 0) ? act_mode :
				(TY == 2) ? 2'b00 : react_mode;
			// RULE10: idle energy contributes zero
			wire signed [32:0] c = idle[gi] ? 33'sh0 : contrib(p, mode);
			wire [41:0] add_c = smp ? {{9{c[32]}}, c} : 42'h0;
			// RULE15: signed 42-bit internal sum
			wire [41:0] sum   = int_nrg[gi] + add_c;
			// RULE3: sign fills the user register top
			wire [44:0] sum_x = {{3{sum[41]}}, sum};
			// RULE21: read with reset zeroes the high part only
			wire        rclr  = rd_fire & rdrst_en & in_user &
				user_hi & user_idx == 4'(gi);
			wire [44:0] base  = rclr ?
				{32'h0, user_nrg[gi][12:0]} : user_nrg[gi];
			wire [43:0] wtot  = wsum[gi] + mag(p);
			// RULE9: threshold picked by energy type
			wire [31:0] t     = (TY == 0) ? thr[0] :
				(TY == 2) ? thr[2] : thr[1];
			// RULE6: idle decided for this phase and energy alone
			assign next_idle[gi] = !win_on ? 1'b0 :
				win_end ? ((wtot >> win_sel) < {12'h000, t}) :
				idle[gi];

			// internal and user energy update
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					int_nrg[gi]  <= 42'h0;
					user_nrg[gi] <= 45'h0;
				// RULE20: tick loads or adds, then restarts at zero
				end else if (tick) begin
					int_nrg[gi]  <= 42'h0;
					user_nrg[gi] <= load_sel ? sum_x : base + sum_x;
				end else begin
					int_nrg[gi]  <= sum;
					user_nrg[gi] <= base;
				end
			end

			// window sum and power accumulation
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					wsum[gi]   <= 44'h0;
					pacc[gi]   <= 42'h0;
					pacc_q[gi] <= 32'h0;
				end else begin
					// RULE24: restart the window at its end
					if (!win_on || win_end)
						wsum[gi] <= 44'h0;
					else if (smp)
						wsum[gi] <= wtot;
					// RULE11: power accumulates regardless of idle
					if (tick) begin
						pacc_q[gi] <= 32'(({{10{p[31]}}, p} &
							{42{smp}}) + pacc[gi] >> 10);
						pacc[gi]   <= 42'h0;
					end else if (smp) begin
						pacc[gi] <= pacc[gi] + {{10{p[31]}}, p};
					end
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// timers
	// ---------------------------------------------------------------

	// period and window counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_q <= 13'h0000;
			win_q <= 12'h000;
		end else begin
			if (tick)
				per_q <= 13'h0000;
			else if (per_step)
				per_q <= per_q + 13'h0001;
			if (!win_on || win_end)
				win_q <= 12'h000;
			else if (smp)
				win_q <= win_q + 12'h001;
		end
	end

	// ---------------------------------------------------------------
	// idle flags, interrupt and event
	// ---------------------------------------------------------------
	wire [11:0] chg = next_idle ^ idle;
	wire [3:0]  chg_ty = chg[3:0] | chg[7:4] | chg[11:8];

	// flags, sticky status and output pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle                    <= 12'h000;
			status                  <= 4'h0;
			second_interrupt_line_n <= 1'b1;
			event_n                 <= 1'b1;
			energy_update_tick      <= 1'b0;
		end else begin
			// RULE12: flag follows the idle state
			idle <= next_idle;
			// RULE13: a change sets status, set wins over clear
			status <= (status & ~(w_status ? hwdata[3:0] : 4'h0))
				| chg_ty;
			second_interrupt_line_n <= ~|(status & irq_en);
			// RULE14: idle status shown on the event pin
			event_n <= ~(evt_sel & |idle);
			energy_update_tick <= tick;
		end
	end

	// pulse-stage contribution, same values as the energy path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			energy_pulse_output <= '0;
		end else begin
			energy_pulse_output.valid <= smp;
			// data move only with an accepted sample, held otherwise
			if (smp)
				for (int i = 0; i < `EANL_NRG; i++)
					energy_pulse_output.e[i] <= g_pulse_e(i);
		end
	end

	// contribution of energy i for the pulse stage
	function automatic logic [32:0] g_pulse_e(input int i);
		logic [1:0] m;
		m = (i % 4 == 0) ? act_mode : (i % 4 == 2) ? 2'b00 : react_mode;
		g_pulse_e = idle[i] ? 33'h0 : contrib(power_in.p[i], m);
	endfunction

	// ---------------------------------------------------------------
	// bus slave
	// ---------------------------------------------------------------
	assign hresp     = 1'b0;
	assign hreadyout = ~rd_q;

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= 12'h000;
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
		end else begin
			if (req)
				addr_q <= {haddr[11:2], 2'b00};
			wr_q <= req & hwrite;
			rd_q <= req & ~hwrite;
		end
	end

	// read mux, sampled during the wait state
	logic [31:0] rmux;
	always_comb begin
		rmux = 32'h0;
		if (addr_q == `EANL_OFF_ACCUMULATION_MODE_CFG)
			rmux = {28'h0, react_mode, act_mode};
		else if (addr_q == `EANL_OFF_EPCFG)
			rmux = {24'h0, evt_sel, win_sel, rdrst_en, load_sel,
				period_mode, run_en};
		else if (addr_q == `EANL_OFF_PERIOD)
			rmux = {19'h0, period_cnt};
		else if (addr_q == `EANL_OFF_ZXSEL)
			rmux = {30'h0, zx_src};
		else if (addr_q == `EANL_OFF_ACT_THR)
			rmux = thr[0];
		else if (addr_q == `EANL_OFF_REACT_THR)
			rmux = thr[1];
		else if (addr_q == `EANL_OFF_APP_THR)
			rmux = thr[2];
		else if (addr_q == `EANL_OFF_IDLE_FLAGS)
			rmux = {20'h0, idle};
		else if (addr_q == `EANL_OFF_STATUS)
			rmux = {28'h0, status};
		else if (addr_q == `EANL_OFF_IRQ_EN)
			rmux = {28'h0, irq_en};
		// RULE23: high word holds 32 msbs, low word 13 lsbs on top
		else if (in_user && user_hi)
			rmux = user_nrg[user_idx][44:13];
		else if (in_user)
			rmux = {user_nrg[user_idx][12:0], 19'h0};
		else if (in_pacc)
			rmux = pacc_q[pacc_idx];
	end

	// read data register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (rd_fire)
			hrdata <= rmux;
	end

	// register writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_mode    <= 2'b00;
			react_mode  <= 2'b00;
			run_en      <= 1'b0;
			period_mode <= 1'b0;
			load_sel    <= 1'b0;
			rdrst_en    <= 1'b0;
			// RULE8: detection on with shortest window
			win_sel     <= `EANL_RST_WIN;
			evt_sel     <= 1'b0;
			period_cnt  <= `EANL_RST_PERIOD;
			zx_src      <= 2'b00;
			thr         <= '{default: 32'h0};
			irq_en      <= 4'h0;
		end else if (wr_fire) begin
			if (addr_q == `EANL_OFF_ACCUMULATION_MODE_CFG) begin
				act_mode   <= hwdata[1:0];
				react_mode <= hwdata[3:2];
			end else if (w_cfg) begin
				run_en      <= hwdata[`EANL_CFG_RUN];
				period_mode <= hwdata[`EANL_CFG_PMODE];
				load_sel    <= hwdata[`EANL_CFG_LOAD];
				rdrst_en    <= hwdata[`EANL_CFG_RDRST];
				win_sel     <= hwdata[`EANL_CFG_WIN_LSB +: 3];
				evt_sel     <= hwdata[`EANL_CFG_EVT];
			// RULE17: 13-bit period count
			end else if (addr_q == `EANL_OFF_PERIOD) begin
				period_cnt <= hwdata[12:0];
			end else if (addr_q == `EANL_OFF_ZXSEL) begin
				zx_src <= hwdata[1:0];
			end else if (addr_q == `EANL_OFF_ACT_THR) begin
				thr[0] <= hwdata;
			end else if (addr_q == `EANL_OFF_REACT_THR) begin
				thr[1] <= hwdata;
			end else if (addr_q == `EANL_OFF_APP_THR) begin
				thr[2] <= hwdata;
			end else if (addr_q == `EANL_OFF_IRQ_EN) begin
				irq_en <= hwdata[3:0];
			end
		end
	end

endmodule

`default_nettype wire

//--- verif/eanl_ctrl_monitor.sv
// Purpose: port-level checks on the energy accumulation control block
// Assumes: one clock hclk, asynchronous active-low hresetn
// Notes:   bound to every eanl_ctrl instance at the foot of this file
`timescale 1ns/1ps
`default_nettype none

module eanl_ctrl_monitor (
	input wire logic                  hclk,
	input wire logic                  hresetn,
	input wire logic                  hsel,
	input wire logic [1:0]            htrans,
	input wire logic                  hwrite,
	input wire logic                  hready,
	input wire logic                  hreadyout,
	input wire logic                  hresp,
	input wire logic [31:0]           hrdata,
	input wire eanl_pkg::eanl_power_s power_in,
	input wire logic [3:0]            zx_pulse,
	input wire eanl_pkg::eanl_pulse_s energy_pulse_output,
	input wire logic                  energy_update_tick
);
	// ------------------------------------------------------------
	// clocking and decoded requests
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	wire logic rd_take = hsel && hready && htrans[1] && !hwrite; // read taken
	wire logic wr_take = hsel && hready && htrans[1] && hwrite;  // write taken
	wire logic no_step = !power_in.valid && (zx_pulse == 4'h0); // no count step

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	resp_okay_a: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	read_wait_a: assert property (rd_take |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	write_nowait_a: assert property (wr_take |=> hreadyout)
		else $error("write was stalled");
	wait_cause_a: assert property ($fell(hreadyout) |-> $past(rd_take))
		else $error("wait state without a read");
	rdata_hold_a: assert property (!$stable(hrdata) |-> !$past(hreadyout))
		else $error("read data moved outside a read");
	tick_cause_a: assert property (no_step [*3] |-> !energy_update_tick)
		else $error("update tick without a count step");
	pulse_cause_a: assert property (
		energy_pulse_output.valid |-> $past(power_in.valid))
		else $error("pulse contribution without a sample");
	pulse_hold_a: assert property (
		!$past(power_in.valid) |-> $stable(energy_pulse_output.e))
		else $error("pulse contribution moved without a sample");

	// main scenarios reached
	cover property (energy_update_tick);
	cover property (rd_take ##2 hreadyout);
	cover property (energy_pulse_output.valid);
endmodule

bind eanl_ctrl eanl_ctrl_monitor u_mon (
	.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .hrdata, .power_in, .zx_pulse, .energy_pulse_output,
	.energy_update_tick
);

`default_nettype wire

//--- verif/eanl_ctrl_tb.sv
// Purpose: self-checking bench for the energy accumulation control block
// Assumes: samples of 8 and -4 alternate on phase a active and reactive
// Notes:   period 3 gives one update tick every four samples
`timescale 1ns/1ps
`include "eanl_map.svh"
`default_nettype none

module testbench;
	// ------------------------------------------------------------
	// signals and bookkeeping
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]  mode; // sign mode, active and reactive alike
		logic        load; // 1 overwrites the user register
		logic [31:0] hi;   // expected high word
		logic [31:0] lo;   // expected low word
	} eanl_tb_row_s;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] w;
		logic [31:0] e;
	} eanl_tb_reg_s;

	logic                  hclk, hresetn, hsel, hwrite;
	logic [11:0]           haddr;
	logic [1:0]            htrans;
	logic [2:0]            hsize;
	logic [31:0]           hwdata, hrdata;
	logic                  hreadyout, hresp, tick, irq_n, event_n;
	logic [3:0]            zx_pulse;
	eanl_pkg::eanl_power_s power_in;
	eanl_pkg::eanl_pulse_s pulse_out;
	int                    fail_count, n_tests, ticks, cycles;
	eanl_tb_row_s          rows [6];
	eanl_tb_reg_s          regs [6];

	eanl_ctrl uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .power_in(power_in), .zx_pulse(zx_pulse),
		.energy_pulse_output(pulse_out), .energy_update_tick(tick),
		.second_interrupt_line_n(irq_n), .event_n(event_n));

	// 50 MHz clock
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	// tick counting and hang guard
	always @(posedge hclk) begin
		cycles = cycles + 1;
		if (tick === 1'b1)
			ticks = ticks + 1;
		if (cycles == 5000) begin
			fail_count = fail_count + 1;
			close_out;
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one ahb-lite single transfer, entered just after a rising edge
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rv);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rv = hrdata;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask

	// n back-to-back samples, entries 0 and 1 alternate a and b
	task automatic send(input int n, input logic [31:0] a,
		input logic [31:0] b);
		for (int k = 0; k < n; k++) begin
			for (int i = 0; i < 12; i++)
				power_in.p[i] <= (i < 2) ? (k[0] ? b : a) : 32'd1000;
			power_in.valid <= 1'b1;
			@(posedge hclk);
		end
		power_in.valid <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask

	task automatic close_out;
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		{hsel, hwrite, haddr, htrans, hwdata} = '0;
		hsize = 3'h2;
		hresetn = 1'b0;
		power_in = '0;
		zx_pulse = 4'h0;
		{fail_count, n_tests, ticks, cycles} = '0;
		// sign mode rows: signed sums 8, abs 24, pos 16, neg -8
		rows = '{'{2'b11, 1'b1, 32'hffffffff, 32'hffc00000},
			'{2'b01, 1'b1, 32'h0, 32'h00c00000},
			'{2'b10, 1'b1, 32'h0, 32'h00800000},
			'{2'b00, 1'b1, 32'h0, 32'h00400000},
			'{2'b00, 1'b0, 32'h0, 32'h00800000},
			'{2'b11, 1'b0, 32'h0, 32'h00400000}};
		regs = '{'{`EANL_OFF_PERIOD, 32'hffffffff, 32'h00001fff},
			'{`EANL_OFF_ZXSEL, 32'hffffffff, 32'h00000003},
			'{`EANL_OFF_ACT_THR, 32'h12345678, 32'h12345678},
			'{`EANL_OFF_REACT_THR, 32'ha5a5a5a5, 32'ha5a5a5a5},
			'{`EANL_OFF_IDLE_FLAGS, 32'hffffffff, 32'h0},
			'{12'h0fc, 32'hffffffff, 32'h0}};
		repeat (5) @(posedge hclk);
		chk({31'h0, hreadyout}, 32'h1);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset leaves detection on with the shortest window
		rdchk(`EANL_OFF_EPCFG, 32'h0);
		for (int r = 0; r < 6; r++) begin
			wr(regs[r].a, regs[r].w);
			rdchk(regs[r].a, regs[r].e);
		end
		wr(`EANL_OFF_PERIOD, 32'h3);
		for (int r = 0; r < 6; r++) begin
			wr(`EANL_OFF_ACCUMULATION_MODE_CFG, {28'h0, rows[r].mode, rows[r].mode});
			wr(`EANL_OFF_EPCFG, {25'h0, 3'h7, 1'b0, rows[r].load, 2'b01});
			ticks = 0;
			send(4, 32'd8, 32'hfffffffc);
			chk(32'(ticks), 32'h1);
			rdchk(`EANL_OFF_USER_BASE, rows[r].hi);
			rdchk(`EANL_OFF_USER_BASE + 12'h004, rows[r].lo);
			rdchk(`EANL_OFF_USER_BASE + 12'h008, rows[r].hi);
			rdchk(`EANL_OFF_USER_BASE + 12'h00c, rows[r].lo);
		end
		// half-cycle mode counts only the selected zero-crossing source
		wr(`EANL_OFF_PERIOD, 32'h1);
		wr(`EANL_OFF_ZXSEL, 32'h2);
		wr(`EANL_OFF_EPCFG, 32'h00000073);
		ticks = 0;
		for (int k = 0; k < 5; k++) begin
			zx_pulse <= (k < 3) ? 4'h2 : 4'h4;
			@(posedge hclk);
			zx_pulse <= 4'h0;
			@(posedge hclk);
		end
		repeat (3) @(posedge hclk);
		chk(32'(ticks), 32'h1);
		// all active energies fall idle, every other energy stays loaded
		wr(`EANL_OFF_ACCUMULATION_MODE_CFG, 32'h0);
		wr(`EANL_OFF_PERIOD, 32'h3);
		wr(`EANL_OFF_ACT_THR, 32'h10000);
		wr(`EANL_OFF_REACT_THR, 32'h0);
		wr(`EANL_OFF_APP_THR, 32'h0);
		wr(`EANL_OFF_IRQ_EN, 32'h1);
		wr(`EANL_OFF_EPCFG, 32'h00000085);
		send(128, 32'd1, 32'd1);
		chk(pulse_out.e[0][31:0], 32'h0);
		chk(pulse_out.e[1][31:0], 32'h1);
		rdchk(`EANL_OFF_IDLE_FLAGS, 32'h111);
		rdchk(`EANL_OFF_USER_BASE + 12'h004, 32'h0);
		rdchk(`EANL_OFF_USER_BASE + 12'h00c, 32'h00200000);
		// phase b active is idle yet its power keeps accumulating
		rdchk(`EANL_OFF_PACC_BASE + 12'h010, 32'h3);
		rdchk(`EANL_OFF_STATUS, 32'h1);
		chk({31'h0, irq_n}, 32'h0);
		chk({31'h0, event_n}, 32'h0);
		wr(`EANL_OFF_IRQ_EN, 32'h0);
		wr(`EANL_OFF_STATUS, 32'h1);
		rdchk(`EANL_OFF_STATUS, 32'h0);
		chk({31'h0, irq_n}, 32'h1);
		// window code 7 switches detection off
		wr(`EANL_OFF_EPCFG, 32'h000000f5);
		rdchk(`EANL_OFF_IDLE_FLAGS, 32'h0);
		chk({31'h0, event_n}, 32'h1);
		// run bit cleared: samples are ignored
		wr(`EANL_OFF_EPCFG, 32'h00000070);
		ticks = 0;
		send(8, 32'd8, 32'd8);
		chk(32'(ticks), 32'h0);
		// clear-on-read empties the high word only
		wr(`EANL_OFF_ACCUMULATION_MODE_CFG, 32'hf);
		wr(`EANL_OFF_EPCFG, 32'h0000007d);
		send(4, 32'd8, 32'hfffffffc);
		rdchk(`EANL_OFF_USER_BASE, 32'hffffffff);
		rdchk(`EANL_OFF_USER_BASE, 32'h0);
		rdchk(`EANL_OFF_USER_BASE + 12'h004, 32'hffc00000);
		// window code 1 decides on the 128th sample, not before
		wr(`EANL_OFF_EPCFG, 32'h00000011);
		send(127, 32'd1, 32'd1);
		rdchk(`EANL_OFF_IDLE_FLAGS, 32'h0);
		send(1, 32'd1, 32'd1);
		rdchk(`EANL_OFF_IDLE_FLAGS, 32'h111);
		close_out;
	end
endmodule

`default_nettype wire
